// ===== bench/rsd_reset_seq_sva.sv
`default_nettype none
module rsd_reset_seq_chk #(
	parameter int unsigned STAB_CYCLES = 20
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Reset pin and vector fetch
	input  wire logic        ext_reset_n,
	input  wire logic [11:0] prom_addr,
	input  wire logic        prom_rd,
	// CPU control
	input  wire logic        cpu_clk_en,
	input  wire logic        cpu_run,
	input  wire logic        state_retained
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned hi_reg;
	int unsigned hi_next;
	// Edges since the pin went high, saturating
	always_comb begin
		hi_next = hi_reg;
		if (!ext_reset_n)
			hi_next = 0;
		else if (hi_reg < STAB_CYCLES + 16)
			hi_next = hi_reg + 1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hi_reg <= 0;
		else
			hi_reg <= hi_next;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_hold_idle;
		!ext_reset_n [*4] |-> !cpu_run && !cpu_clk_en;
	endproperty
	a_hold_idle: assert property (p_hold_idle)
		else $error("cpu not idle during reset");
	property p_hold_no_fetch;
		!ext_reset_n [*4] |-> !prom_rd;
	endproperty
	a_hold_no_fetch: assert property (p_hold_no_fetch)
		else $error("vector fetch during reset");
	property p_clk_needs_run;
		cpu_clk_en |-> cpu_run;
	endproperty
	a_clk_needs_run: assert property (p_clk_needs_run)
		else $error("cpu clock on outside run");
	property p_run_late;
		$rose(cpu_run) |-> hi_reg >= STAB_CYCLES;
	endproperty
	a_run_late: assert property (p_run_late)
		else $error("run before stabilization");
	property p_run_in_time;
		hi_reg == STAB_CYCLES + 8 |-> cpu_run;
	endproperty
	a_run_in_time: assert property (p_run_in_time)
		else $error("run not resumed");
	property p_fetch_seq;
		prom_rd && prom_addr == 12'h000 |=> prom_rd && prom_addr == 12'h001;
	endproperty
	a_fetch_seq: assert property (p_fetch_seq)
		else $error("second vector byte not fetched");
	property p_fetch_end;
		prom_rd && prom_addr == 12'h001 |=> !prom_rd;
	endproperty
	a_fetch_end: assert property (p_fetch_end)
		else $error("vector fetch overran");
	property p_retain_quiet;
		$changed(state_retained) |-> !cpu_run;
	endproperty
	a_retain_quiet: assert property (p_retain_quiet)
		else $error("retain flag moved while running");
	property p_run_clk;
		$rose(cpu_run) |-> cpu_clk_en;
	endproperty
	a_run_clk: assert property (p_run_clk)
		else $error("power mode not normal after reset");
endmodule
bind rsd_reset_seq rsd_reset_seq_chk #(.STAB_CYCLES(STAB_CYCLES)) u_chk (
	.pclk(pclk), .presetn(presetn), .ext_reset_n(ext_reset_n),
	.prom_addr(prom_addr), .prom_rd(prom_rd), .cpu_clk_en(cpu_clk_en),
	.cpu_run(cpu_run), .state_retained(state_retained)
);
`default_nettype wire

// ===== bench/rsd_rst_src.sv
`default_nettype none
module rsd_rst_src #(
	parameter logic [7:0] VEC0 = 8'hCF,
	parameter logic [7:0] VEC1 = 8'h3A
) (
	// Clock
	input  wire logic        pclk,
	// Vector fetch
	input  wire logic [11:0] prom_addr,
	input  wire logic        prom_rd,
	output var  logic [7:0]  prom_data,
	// Reset pin
	output var  logic        ext_reset_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] byte_sel;
	assign byte_sel = (prom_addr == 12'h001) ? VEC1 : VEC0;
	// Inverted when not read, so a stray sample shows
	assign prom_data = prom_rd ? byte_sel : ~byte_sel;
	initial ext_reset_n = 1'b1;
	task automatic pulse(input int cycles);
		@(posedge pclk);
		ext_reset_n <= 1'b0;
		repeat (cycles) @(posedge pclk);
		ext_reset_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ===== bench/tb_reset_sequence_and_defaults.sv
`include "rsd_cfg.svh"
`default_nettype none
module tb_reset_sequence_and_defaults;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ext_reset_n;
	logic [11:0] prom_addr;
	logic        prom_rd;
	logic [7:0]  prom_data;
	logic        cpu_clk_en;
	logic        cpu_run;
	logic        state_retained;
	logic [31:0] rdata;
	logic        rerr;
	int          mismatches = 0;
	int          total_checks = 0;

	rsd_reset_seq #(.STAB_CYCLES(20)) DUT (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ext_reset_n, .prom_addr, .prom_rd,
		.prom_data, .cpu_clk_en, .cpu_run, .state_retained
	);
	rsd_rst_src u_src (
		.pclk, .prom_addr, .prom_rd, .prom_data, .ext_reset_n
	);

	initial begin
		forever #20 pclk = ~pclk;
	end

	task automatic print_verdict;
		if (mismatches == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// Holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdata, exp);
	endtask

	task automatic wait_run;
		int n;
		n = 0;
		while (cpu_run !== 1'b1 && n < 500) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, cpu_run}, 32'h1);
	endtask

	task automatic s_boot;
		wait_run();
		rd(`RSD_OFF_PC, 32'h73A);
		rd(`RSD_OFF_PSW, 32'hC0);
		rd(`RSD_OFF_STAT, 32'h14);
		apb(1'b0, 8'h30, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		chk(rdata, 32'h0);
	endtask

	task automatic s_normal;
		wr(`RSD_OFF_PSW, 32'hFF);
		wr(`RSD_OFF_BANK, 32'hFFF);
		wr(`RSD_OFF_CLK, 32'hF3);
		wr(`RSD_OFF_IRQ, 32'hFF);
		wr(`RSD_OFF_IEN, 32'h1FFF);
		wr(`RSD_OFF_IMOD, 32'hFFF);
		wr(`RSD_OFF_SERIAL_SHIFT_BUFFER, 32'h5A);
		u_src.pulse(5);
		wait_run();
		rd(`RSD_OFF_PSW, 32'hC0);
		rd(`RSD_OFF_BANK, 32'h0);
		rd(`RSD_OFF_CLK, 32'h0);
		rd(`RSD_OFF_IRQ, 32'h0);
		rd(`RSD_OFF_IEN, 32'h0);
		rd(`RSD_OFF_IMOD, 32'h0);
		rd(`RSD_OFF_SERIAL_SHIFT_BUFFER, 32'h0);
		rd(`RSD_OFF_STAT, 32'h14);
	endtask

	task automatic s_retain;
		wr(`RSD_OFF_PSW, 32'h01);
		wr(`RSD_OFF_SERIAL_SHIFT_BUFFER, 32'hA5);
		wr(8'h5C, 32'h9);
		wr(`RSD_OFF_CLK, 32'h4);
		// Gate updates at the write's own edge; look one edge later
		@(posedge pclk);
		chk({31'h0, cpu_clk_en}, 32'h0);
		u_src.pulse(5);
		wait_run();
		rd(`RSD_OFF_PSW, 32'hC1);
		rd(`RSD_OFF_SERIAL_SHIFT_BUFFER, 32'hA5);
		rd(8'h5C, 32'h9);
		rd(`RSD_OFF_CLK, 32'h0);
		rd(`RSD_OFF_STAT, 32'h1C);
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		s_boot();
		s_normal();
		s_retain();
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		print_verdict();
	end
endmodule
`default_nettype wire

// ===== include/rsd_cfg.svh
`ifndef RSD_CFG_SVH
`define RSD_CFG_SVH

// Register byte offsets
`define RSD_OFF_PSW     8'h00
`define RSD_OFF_BANK    8'h04
`define RSD_OFF_CLK     8'h08
`define RSD_OFF_IRQ     8'h0C
`define RSD_OFF_IEN     8'h10
`define RSD_OFF_IMOD    8'h14
`define RSD_OFF_PC      8'h18
`define RSD_OFF_STAT    8'h1C
`define RSD_OFF_SERIAL_SHIFT_BUFFER    8'h20
`define RSD_OFF_GPR     8'h40
`define RSD_GPR_COUNT   8

// Program memory vector locations
`define RSD_VEC_ADDR0   12'h000
`define RSD_VEC_ADDR1   12'h001
// Bank enable bit positions in the first vector byte
`define RSD_VEC_ERB_BIT 6
`define RSD_VEC_EMB_BIT 7

// Power mode request field of power_control_reg
`define RSD_PMODE_HI    3
`define RSD_PMODE_LO    2
`define RSD_PMODE_RUN   2'h0

// Stabilization time
`define RSD_STAB_NS     31300000
`define RSD_CLK_NS      40
`define RSD_STAB_CYC    ((`RSD_STAB_NS + `RSD_CLK_NS - 1) / `RSD_CLK_NS)

`endif

// ===== include/rsd_pkg.sv
`default_nettype none
package rsd_pkg;

	typedef enum logic [2:0] {
		RSD_HOLD,
		RSD_FETCH0,
		RSD_FETCH1,
		RSD_STAB,
		RSD_RUN
	} rsd_state_t;

	// Core control state restored by the sequencer
	typedef struct packed {
		logic       carry;
		logic [2:0] skip_condition_bits;
		logic [1:0] interrupt_status_bits;
		logic       register_bank_enable;
		logic       extended_memory_bank_enable;
		logic [3:0] memory_bank_select;
		logic [3:0] register_bank_select;
		logic [3:0] bit_sequential_carrier;
		logic [3:0] power_control_reg;
		logic [3:0] clock_output_mode_reg;
		logic [7:0] interrupt_request_flags;
		logic [7:0] interrupt_enable_flags;
		logic [3:0] interrupt_priority_flag;
		logic       master_interrupt_enable;
		logic [3:0] ext_irq0_mode;
		logic [3:0] ext_irq1_mode;
		logic [3:0] key_irq_mode;
		logic [11:0] pc;
		logic [7:0] serial_shift_buffer;
	} rsd_core_t;

endpackage
`default_nettype wire

// ===== rtl/rsd_reset_seq.sv
`include "rsd_cfg.svh"
`default_nettype none
module rsd_reset_seq
	import rsd_pkg::*;
#(
	parameter int unsigned STAB_CYCLES = `RSD_STAB_CYC
) (
	// Clock and bus reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// External reset pin
	input  wire logic        ext_reset_n,
	// Program memory vector fetch
	output var  logic [11:0] prom_addr,
	output var  logic        prom_rd,
	input  wire logic [7:0]  prom_data,
	// CPU control
	output var  logic        cpu_clk_en,
	output var  logic        cpu_run,
	output var  logic        state_retained
);

	// Twenty bits cover the full interval at the bus clock
	localparam logic [19:0] STAB_LAST = 20'(STAB_CYCLES - 1);

	function automatic logic is_gpr(input logic [7:0] a);
		is_gpr = (a >= `RSD_OFF_GPR) &&
			(a < (`RSD_OFF_GPR + 8'(4 * `RSD_GPR_COUNT)));
	endfunction

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = is_gpr(a) || a == `RSD_OFF_PSW ||
			a == `RSD_OFF_BANK || a == `RSD_OFF_CLK ||
			a == `RSD_OFF_IRQ || a == `RSD_OFF_IEN ||
			a == `RSD_OFF_IMOD || a == `RSD_OFF_PC ||
			a == `RSD_OFF_STAT || a == `RSD_OFF_SERIAL_SHIFT_BUFFER;
	endfunction

	// Pin synchroniser, first stage read only by the second
	logic       rst_meta_reg;
	logic       rst_sync_reg;

	rsd_state_t state_reg;
	rsd_state_t state_next;
	rsd_core_t  core_reg;
	rsd_core_t  core_next;
	logic [3:0] gpr_reg [`RSD_GPR_COUNT];
	logic [3:0] gpr_next [`RSD_GPR_COUNT];
	logic [19:0] cnt_reg;
	logic [19:0] cnt_next;
	logic        retain_reg;
	logic        retain_next;
	logic [11:0] prom_addr_next;
	logic        prom_rd_next;
	logic        cpu_clk_en_next;
	logic        cpu_run_next;
	logic [31:0] prdata_next;
	logic        pready_next;
	logic        pslverr_next;
	logic        wr_ok;
	logic [2:0]  gidx;
	logic [1:0]  pmode;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Reads as pin low: power-up also waits the interval
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= ext_reset_n;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// One working register per word
	assign gidx  = paddr[4:2];
	assign pmode = core_reg.power_control_reg[`RSD_PMODE_HI:`RSD_PMODE_LO];
	assign wr_ok = psel && penable && pready && pwrite && !pslverr;

	// Read data and strobe are prepared in the setup cycle: zero wait
	always_comb begin
		prdata_next  = 32'h0000_0000;
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		if (psel && !penable) begin
			pready_next  = 1'b1;
			pslverr_next = !known_addr(paddr);
			if (paddr == `RSD_OFF_PSW) begin
				prdata_next[7:0] = {core_reg.extended_memory_bank_enable,
					core_reg.register_bank_enable,
					core_reg.interrupt_status_bits,
					core_reg.skip_condition_bits, core_reg.carry};
			end else if (paddr == `RSD_OFF_BANK) begin
				prdata_next[11:0] = {core_reg.bit_sequential_carrier,
					core_reg.register_bank_select,
					core_reg.memory_bank_select};
			end else if (paddr == `RSD_OFF_CLK) begin
				prdata_next[7:0] = {core_reg.clock_output_mode_reg,
					core_reg.power_control_reg};
			end else if (paddr == `RSD_OFF_IRQ) begin
				prdata_next[7:0] = core_reg.interrupt_request_flags;
			end else if (paddr == `RSD_OFF_IEN) begin
				prdata_next[12:0] = {core_reg.master_interrupt_enable,
					core_reg.interrupt_priority_flag,
					core_reg.interrupt_enable_flags};
			end else if (paddr == `RSD_OFF_IMOD) begin
				prdata_next[11:0] = {core_reg.key_irq_mode,
					core_reg.ext_irq1_mode, core_reg.ext_irq0_mode};
			end else if (paddr == `RSD_OFF_PC) begin
				prdata_next[11:0] = core_reg.pc;
			end else if (paddr == `RSD_OFF_STAT) begin
				// Status is read-only; the write decoder skips it
				prdata_next[4:0] = {cpu_run, retain_reg, state_reg};
			end else if (paddr == `RSD_OFF_SERIAL_SHIFT_BUFFER) begin
				prdata_next[7:0] = core_reg.serial_shift_buffer;
			end else if (is_gpr(paddr)) begin
				prdata_next[3:0] = gpr_reg[gidx];
			end
		end
	end

	always_comb begin
		core_next      = core_reg;
		gpr_next       = gpr_reg;
		state_next     = state_reg;
		cnt_next       = cnt_reg;
		retain_next    = retain_reg;
		prom_addr_next = prom_addr;
		prom_rd_next   = 1'b0;
		// Software writes first; reset clears below override them
		if (wr_ok) begin
			if (paddr == `RSD_OFF_PSW) begin
				{core_next.extended_memory_bank_enable,
					core_next.register_bank_enable,
					core_next.interrupt_status_bits,
					core_next.skip_condition_bits,
					core_next.carry} = pwdata[7:0];
			end else if (paddr == `RSD_OFF_BANK) begin
				{core_next.bit_sequential_carrier,
					core_next.register_bank_select,
					core_next.memory_bank_select} = pwdata[11:0];
			end else if (paddr == `RSD_OFF_CLK) begin
				{core_next.clock_output_mode_reg,
					core_next.power_control_reg} = pwdata[7:0];
			end else if (paddr == `RSD_OFF_IRQ) begin
				core_next.interrupt_request_flags = pwdata[7:0];
			end else if (paddr == `RSD_OFF_IEN) begin
				{core_next.master_interrupt_enable,
					core_next.interrupt_priority_flag,
					core_next.interrupt_enable_flags} = pwdata[12:0];
			end else if (paddr == `RSD_OFF_IMOD) begin
				{core_next.key_irq_mode, core_next.ext_irq1_mode,
					core_next.ext_irq0_mode} = pwdata[11:0];
			end else if (paddr == `RSD_OFF_PC) begin
				core_next.pc = pwdata[11:0];
			end else if (paddr == `RSD_OFF_SERIAL_SHIFT_BUFFER) begin
				core_next.serial_shift_buffer = pwdata[7:0];
			end else if (is_gpr(paddr)) begin
				gpr_next[gidx] = pwdata[3:0];
			end
		end
		case (state_reg)
			RSD_HOLD: begin
				if (rst_sync_reg) begin
					state_next = RSD_FETCH0;
				end
			end
			RSD_FETCH0: begin
				prom_addr_next = `RSD_VEC_ADDR0;
				prom_rd_next   = 1'b1;
				state_next     = RSD_FETCH1;
			end
			RSD_FETCH1: begin
				core_next.pc[11:8] = {1'b0, prom_data[2:0]};
				core_next.register_bank_enable =
					prom_data[`RSD_VEC_ERB_BIT];
				core_next.extended_memory_bank_enable =
					prom_data[`RSD_VEC_EMB_BIT];
				prom_addr_next = `RSD_VEC_ADDR1;
				prom_rd_next   = 1'b1;
				state_next     = RSD_STAB;
			end
			RSD_STAB: begin
				// First STAB cycle also catches the low vector byte
				if (prom_rd) begin
					core_next.pc[7:0] = prom_data;
				end
				if (cnt_reg >= STAB_LAST) begin
					state_next = RSD_RUN;
				end
			end
			default: begin
				state_next = RSD_RUN;
			end
		endcase
		// Counting starts at release; fetch cycles are part of it
		// Stops in RUN, so the counter never wraps
		if (state_reg != RSD_HOLD && state_reg != RSD_RUN) begin
			cnt_next = cnt_reg + 20'h00001;
		end
		if (!rst_sync_reg) begin
			state_next = RSD_HOLD;
			cnt_next   = 20'h00000;
			// A read already issued may finish; it is fetched again
			// after release, so a stray byte does no harm
			// Mode is judged once, from the cycle the reset arrives
			// A reset during fetch or wait finds the CPU idle
			if (state_reg != RSD_HOLD) begin
				retain_next = (state_reg != RSD_RUN) ||
					(pmode != `RSD_PMODE_RUN);
			end
			core_next.skip_condition_bits        = 3'h0;
			core_next.interrupt_status_bits      = 2'h0;
			core_next.memory_bank_select         = 4'h0;
			core_next.register_bank_select       = 4'h0;
			core_next.bit_sequential_carrier     = 4'h0;
			core_next.power_control_reg          = 4'h0;
			core_next.clock_output_mode_reg      = 4'h0;
			core_next.interrupt_request_flags    = 8'h00;
			core_next.interrupt_enable_flags     = 8'h00;
			core_next.interrupt_priority_flag    = 4'h0;
			core_next.master_interrupt_enable    = 1'b0;
			core_next.ext_irq0_mode              = 4'h0;
			core_next.ext_irq1_mode              = 4'h0;
			core_next.key_irq_mode               = 4'h0;
			// Normal-mode reset leaves these undefined; zero is chosen
			if (!retain_next) begin
				core_next.carry               = 1'b0;
				core_next.serial_shift_buffer = 8'h00;
				for (int i = 0; i < `RSD_GPR_COUNT; i++) begin
					gpr_next[i] = 4'h0;
				end
			end
		end
		cpu_run_next    = (state_next == RSD_RUN);
		// Idle or stop request keeps the CPU clock gated in RUN
		cpu_clk_en_next = cpu_run_next &&
			(core_next.power_control_reg[`RSD_PMODE_HI:`RSD_PMODE_LO] ==
			`RSD_PMODE_RUN);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg      <= RSD_HOLD;
			core_reg       <= '0;
			cnt_reg        <= 20'h00000;
			retain_reg     <= 1'b0;
			prom_addr      <= 12'h000;
			prom_rd        <= 1'b0;
			cpu_clk_en     <= 1'b0;
			cpu_run        <= 1'b0;
			prdata         <= 32'h0000_0000;
			pready         <= 1'b0;
			pslverr        <= 1'b0;
			for (int i = 0; i < `RSD_GPR_COUNT; i++) begin
				gpr_reg[i] <= 4'h0;
			end
		end else begin
			state_reg      <= state_next;
			core_reg       <= core_next;
			cnt_reg        <= cnt_next;
			retain_reg     <= retain_next;
			prom_addr      <= prom_addr_next;
			prom_rd        <= prom_rd_next;
			cpu_clk_en     <= cpu_clk_en_next;
			cpu_run        <= cpu_run_next;
			prdata         <= prdata_next;
			pready         <= pready_next;
			pslverr        <= pslverr_next;
			gpr_reg        <= gpr_next;
		end
	end

	assign state_retained = retain_reg;

endmodule
`default_nettype wire
